// [port_pkg.sv]
// Package for the I/O port controller: register map, field layout, types.
// Assumes a 32-bit APB slave with one aligned word per register.
package port_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] PROT_OFS     = 12'h000;
   localparam logic [11:0] CLKCTL_OFS   = 12'h004;
   localparam logic [11:0] IOEN_OFS     = 12'h008;
   localparam logic [11:0] DATA_OFS     = 12'h00C;
   localparam logic [11:0] PULL_OFS     = 12'h010;
   localparam logic [11:0] FILT_OFS     = 12'h014;
   localparam logic [11:0] FUNC_OFS     = 12'h018;
   localparam logic [11:0] MODE_OFS     = 12'h01C;
   localparam logic [11:0] STATUS_OFS   = 12'h020;

   // ==========================================================
   // Field positions and values
   localparam logic [15:0] UNLOCK_KEY    = 16'h0096;
   localparam int          CLKSRC_LSB    = 0;
   localparam int          CLKDIV_LSB    = 4;
   localparam int          RUN_IN_DEBUG_BIT     = 8;
   localparam int          SLPSTOP_BIT   = 9;
   localparam int          IOEN_OUT_LSB  = 8;
   localparam int          DATA_IN_LSB   = 8;
   localparam int          PULL_SEL_LSB  = 8;
   localparam logic [1:0]  CLKSRC_RST    = 2'h0;
   localparam logic [3:0]  CLKDIV_RST    = 4'h0;
   localparam int          FILT_STAGES   = 3;

   // Per-pin settings carried together
   typedef struct packed {
      logic       in_en;
      logic       out_en;
      logic       pull_en;
      logic       pull_up;
      logic       filt_en;
      logic       periph;
      logic [1:0] func;
   } pin_cfg_s;

   // APB access phases
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_SETUP,
      BUS_ACCESS
   } bus_state_e;

endpackage

// [pin_filter.sv]
// Glitch filter for one pin, on the divided port filter clock enable.
// Assumes the input is already synchronous to core_clk.
`timescale 1ns/1ps
module pin_filter (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic tick,
   input  wire logic pin_in,
   output logic      pin_out
);
   import port_pkg::*;

   logic [1:0] samp_ff;
   logic       out_ff;
   wire        agree = (samp_ff[0] == pin_in) && (samp_ff[1] == pin_in);

   // ==========================================================
   // Output moves only after the input held across port clock ticks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_ff <= 2'h0;
         out_ff  <= 1'b0;
      end else if (tick) begin
         samp_ff <= {samp_ff[0], pin_in};
         if (agree) out_ff <= pin_in;     // Short pulses discarded [RULE18]
      end
   end

   assign pin_out = out_ff;
endmodule // pin_filter

// [port_controller.sv]
// I/O port controller: per-pin pull, filter, function select and clock control.
// Assumes an APB master on core_clk and pins synchronous to core_clk.
// The filter clock is a tick enable on core_clk.
// Every output comes from a flop.
// Debug pins in DBG_MASK never drive.
//
// Behaviour
// [RULE1] Each pin picks pull-up, pull-down or no pull.
// [RULE2] Glitch filter enables per pin.
// [RULE3] Each pin selects GPIO or one of four peripheral functions.
// [RULE4] After reset non-debug pins are high impedance, input and output off.
// [RULE5] Pins grouped eight to a group, index zero to seven.
// [RULE6] Cleared input enable blocks the pin's input path.
// [RULE7] Register control can stop a GPIO pin driving, leaving it high impedance.
// [RULE8] Filter runs only while the port filter clock is supplied.
// [RULE9] Software unlocks protection with the key before clock setup.
// [RULE10] Any non-key protection write relocks protection.
// [RULE11] Two-bit clock source and four-bit divider set the filter clock.
// [RULE12] Software keeps the source running in sleep for sleep filtering.
// [RULE13] Sleep-stop set: clock stops in sleep, filter disabled.
// [RULE14] Run-in-debug clear: clock suspended in debug, resumes after.
// [RULE15] Suspended in debug: filter stops, filtered pins' input deactivated.
// [RULE16] Port registers stay writable while the clock is suspended.
// [RULE17] Run-in-debug set: clock and filter keep running in debug.
// [RULE18] Filter discards pulses shorter than two to three port clocks.
// [RULE19] Software enables pin interrupts four port clocks after filter enable.
// [RULE20] Input data reads pin state sampled one clock before the read.
// [RULE21] Pin inputs are synchronised before filtering.
// [RULE22] Protected clock fields ignore writes while protection is active.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module port_controller #(
   parameter int PINS      = 8,
   parameter int DBG_MASK  = 0,
   parameter int NUM_SRC   = 4
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  sleep_mode,
   input  wire logic                  debug_mode,
   input  wire logic [NUM_SRC-1:0]    src_clk_en,
   input  wire logic [PINS-1:0]       pin_in,
   output logic [PINS-1:0]            pin_out,
   output logic [PINS-1:0]            pin_oe_n,
   output logic [PINS-1:0]            pin_pull_en,
   output logic [PINS-1:0]            pin_pull_up,
   output logic [PINS-1:0]            pin_periph,
   output logic [2*PINS-1:0]          pin_func,
   output logic [PINS-1:0]            periph_in,
   output logic                       protect_on,
   output logic                       filter_clk_run
);
   import port_pkg::*;

   // ==========================================================
   // Configuration registers
   logic                  prot_open_ff;
   logic                  prot_lock_ff;
   logic [1:0]            clksrc_ff;
   logic [3:0]            clkdiv_ff;
   logic                  run_in_debug_ff;
   logic                  slpstop_ff;

   // Pin settings
   logic [PINS-1:0]       ien_ff;
   logic [PINS-1:0]       oen_ff;
   logic [PINS-1:0]       dout_ff;
   logic [PINS-1:0]       pull_en_ff;
   logic [PINS-1:0]       pull_up_ff;
   logic [PINS-1:0]       filt_en_ff;
   logic [PINS-1:0]       periph_ff;
   logic [2*PINS-1:0]     func_ff;

   // Input path
   logic [PINS-1:0]       sync1_ff;
   logic [PINS-1:0]       sync2_ff;
   logic [PINS-1:0]       din_ff;
   logic [PINS-1:0]       filt_out;

   // Divider
   logic [14:0]           div_cnt_ff;
   logic                  tick_ff;
   logic                  clk_run_ff;

   // Bus answer
   logic                  ready_ff;
   logic [31:0]           rdata_ff;
   logic                  err_ff;

   // Bus state
   bus_state_e            bus_ff;
   bus_state_e            nxt_bus;

   // Pad drive
   logic [PINS-1:0]       out_ff;
   logic [PINS-1:0]       oe_n_ff;
   logic [PINS-1:0]       pull_en_pad_ff;
   logic [PINS-1:0]       pull_up_pad_ff;
   logic [PINS-1:0]       periph_in_ff;

   // ==========================================================
   // Bus decode
   wire        setup    = psel && !penable;
   wire        acc      = psel && penable && ready_ff;
   wire        wr       = acc && pwrite;
   wire        key_hit  = (pwdata[15:0] == UNLOCK_KEY);

   // Full address match, no aliases
   wire        hit_prot = (paddr == PROT_OFS);
   wire        hit_clk  = (paddr == CLKCTL_OFS);
   wire        hit_ioen = (paddr == IOEN_OFS);
   wire        hit_data = (paddr == DATA_OFS);
   wire        hit_pull = (paddr == PULL_OFS);
   wire        hit_filt = (paddr == FILT_OFS);
   wire        hit_func = (paddr == FUNC_OFS);
   wire        hit_mode = (paddr == MODE_OFS);
   wire        hit_stat = (paddr == STATUS_OFS);
   // Anything else gets pslverr
   wire        mapped   = hit_prot | hit_clk | hit_ioen | hit_data | hit_pull
                          | hit_filt | hit_func | hit_mode | hit_stat;

   // Pins of the debug interface
   wire [PINS-1:0] dbg_pins = PINS'(DBG_MASK);

   // ==========================================================
   // Filter clock gating: source on, not stopped by sleep or debug
   // A stopped clock freezes all filters.
   wire src_on    = src_clk_en[clksrc_ff];                         // [RULE11]
   wire slp_block = sleep_mode && slpstop_ff;                      // [RULE13]
   wire dbg_block = debug_mode && !run_in_debug_ff;                       // [RULE14] [RULE17]
   wire clk_run   = src_on && !slp_block && !dbg_block;            // [RULE8]

   // Cut to the counter width on purpose
   wire [14:0] div_top = 15'((16'h0001 << clkdiv_ff) - 16'h0001);  // [RULE11]

   // Input path: disabled inputs read zero, filtered when the clock runs
   // Debug halt: filtered pins read zero.
   // Sleep stop: filtered pins pass through.
   wire [PINS-1:0] filt_live = filt_en_ff & {PINS{clk_run}};       // [RULE13]
   wire [PINS-1:0] in_gate   = ien_ff & ~(filt_en_ff & {PINS{dbg_block}}); // [RULE15]
   wire [PINS-1:0] in_sel    = (filt_live & filt_out) | (~filt_live & sync2_ff);
   wire [PINS-1:0] nxt_din   = in_sel & in_gate;                   // [RULE6]

   // Read mux
   // Selects are exclusive; gaps read zero
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (hit_prot) rmux = {31'h0000_0000, prot_open_ff};
      if (hit_clk)  rmux = {22'h000000, slpstop_ff, run_in_debug_ff, clkdiv_ff, 2'h0, clksrc_ff};
      if (hit_ioen) rmux = {16'h0000, 8'(oen_ff), 8'(ien_ff)};
      if (hit_data) rmux = {16'h0000, 8'(din_ff), 8'(dout_ff)};    // [RULE20]
      if (hit_pull) rmux = {16'h0000, 8'(pull_up_ff), 8'(pull_en_ff)};
      if (hit_filt) rmux = {24'h000000, 8'(filt_en_ff)};
      if (hit_func) rmux = {16'h0000, 16'(func_ff)};
      if (hit_mode) rmux = {24'h000000, 8'(periph_ff)};
      if (hit_stat) rmux = {31'h0000_0000, clk_run_ff};
   end

   // Bus state: one wait state after setup so the answer comes from a register
   // Back-to-back setup is taken at once
   // An idle bus stays in BUS_IDLE
   always_comb begin
      case (bus_ff)
         BUS_IDLE:   nxt_bus = setup ? BUS_SETUP : BUS_IDLE;
         BUS_SETUP:  nxt_bus = BUS_ACCESS;
         BUS_ACCESS: nxt_bus = setup ? BUS_SETUP : BUS_IDLE;
         default:    nxt_bus = BUS_IDLE;
      endcase
   end

   // ==========================================================
   // APB answer
   // Answer stands one cycle;
   // prdata is zero outside it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ff   <= BUS_IDLE;
         ready_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else begin
         bus_ff   <= nxt_bus;
         ready_ff <= (nxt_bus == BUS_ACCESS);
         rdata_ff <= (nxt_bus == BUS_ACCESS) ? rmux : 32'h0000_0000;
         err_ff   <= (nxt_bus == BUS_ACCESS) && !mapped;
      end
   end

   // Protection key: key opens, anything else closes
   // The lock flag has its own flop for the pin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_open_ff <= 1'b0;
         prot_lock_ff <= 1'b1;
      end else if (wr && hit_prot) begin
         prot_open_ff <= key_hit;                                  // [RULE9] [RULE10]
         prot_lock_ff <= !key_hit;                                 // [RULE10]
      end
   end

   // Clock control; source and divider locked by protection
   // Debug and sleep bits need no key.
   // Locked fields keep their value.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clksrc_ff  <= CLKSRC_RST;
         clkdiv_ff  <= CLKDIV_RST;
         run_in_debug_ff   <= 1'b0;
         slpstop_ff <= 1'b0;
      end else if (wr && hit_clk) begin
         if (prot_open_ff) begin                                   // [RULE22]
            clksrc_ff <= pwdata[CLKSRC_LSB +: 2];
            clkdiv_ff <= pwdata[CLKDIV_LSB +: 4];
         end
         run_in_debug_ff   <= pwdata[RUN_IN_DEBUG_BIT];
         slpstop_ff <= pwdata[SLPSTOP_BIT];
      end
   end

   // Pin configuration; writable in debug too, reset to Hi-Z GPIO
   // A debug halt stops the clock and gates filtered inputs, not register writes.
   // Input enables low byte, outputs next.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin                                            // [RULE4]
         ien_ff     <= '0;
         oen_ff     <= '0;
         dout_ff    <= '0;
         pull_en_ff <= '0;
         pull_up_ff <= '0;
         filt_en_ff <= '0;
         periph_ff  <= '0;
         func_ff    <= '0;
      end else if (wr) begin                                       // [RULE16]
         if (hit_ioen) begin
            ien_ff <= pwdata[PINS-1:0];
            oen_ff <= pwdata[IOEN_OUT_LSB +: PINS];                // [RULE7]
         end
         if (hit_data) dout_ff <= pwdata[PINS-1:0];
         if (hit_pull) begin                                       // [RULE1]
            pull_en_ff <= pwdata[PINS-1:0];
            pull_up_ff <= pwdata[PULL_SEL_LSB +: PINS];
         end
         if (hit_filt) filt_en_ff <= pwdata[PINS-1:0];             // [RULE2]
         if (hit_func) func_ff <= pwdata[2*PINS-1:0];              // [RULE3]
         if (hit_mode) periph_ff <= pwdata[PINS-1:0];              // [RULE3]
      end
   end

   // ==========================================================
   // Port filter clock divider, stands still when the clock is off
   // One tick every 2^div core clocks;
   // a resumed clock finishes its period.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_ff <= 15'h0000;
         tick_ff    <= 1'b0;
         clk_run_ff <= 1'b0;
      end else begin
         clk_run_ff <= clk_run;
         if (!clk_run) begin                                       // [RULE8]
            tick_ff <= 1'b0;
         end else if (div_cnt_ff >= div_top) begin
            div_cnt_ff <= 15'h0000;
            tick_ff    <= 1'b1;
         end else begin
            div_cnt_ff <= div_cnt_ff + 15'h0001;
            tick_ff    <= 1'b0;
         end
      end
   end

   // Input synchroniser and sampled data
   // Only the second stage is read.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         din_ff   <= '0;
      end else begin
         sync1_ff <= pin_in;                                       // [RULE21]
         sync2_ff <= sync1_ff;
         din_ff   <= nxt_din;                                      // [RULE20]
      end
   end

   // One filter per pin, eight pins a group
   // All filters share one tick
   for (genvar i = 0; i < PINS; i++) begin : g_filt                // [RULE5]
      pin_filter u_filt (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .tick     (tick_ff),
         .pin_in   (sync2_ff[i]),
         .pin_out  (filt_out[i])
      );
   end

   // ==========================================================
   // Pad outputs
   // Pull turns off on the edge the driver turns on
   wire [PINS-1:0] drive_on = oen_ff & ~periph_ff & ~dbg_pins;     // [RULE7]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff         <= '0;
         oe_n_ff        <= '1;                                     // [RULE4]
         pull_en_pad_ff <= '0;                                     // [RULE4]
         pull_up_pad_ff <= '0;
         periph_in_ff   <= '0;
      end else begin
         out_ff         <= dout_ff;
         oe_n_ff        <= ~drive_on;                              // [RULE7]
         pull_en_pad_ff <= pull_en_ff & ~drive_on;                 // [RULE1]
         pull_up_pad_ff <= pull_up_ff;                             // [RULE1]
         periph_in_ff   <= nxt_din & periph_ff;
      end
   end

   // Bus answer
   assign pready         = ready_ff;
   assign prdata         = rdata_ff;
   assign pslverr        = err_ff;

   // Pad and status outputs
   assign pin_out        = out_ff;
   assign pin_oe_n       = oe_n_ff;
   assign pin_pull_en    = pull_en_pad_ff;
   assign pin_pull_up    = pull_up_pad_ff;
   assign pin_periph     = periph_ff;
   assign pin_func       = func_ff;
   assign periph_in      = periph_in_ff;
   assign protect_on     = prot_lock_ff;
   assign filter_clk_run = clk_run_ff;
endmodule // port_controller

// [port_props.sv]
// Checker for the port controller: protection, pins and filter clock gating.
// Assumes APB writes complete at an edge with psel, penable and pready high.
`timescale 1ns/1ps
module port_props #(
   parameter int PINS    = 8,
   parameter int NUM_SRC = 4
) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               sleep_mode,
   input wire logic               debug_mode,
   input wire logic [NUM_SRC-1:0] src_clk_en,
   input wire logic [PINS-1:0]    pin_oe_n,
   input wire logic [PINS-1:0]    pin_pull_en,
   input wire logic [PINS-1:0]    pin_periph,
   input wire logic               protect_on,
   input wire logic               filter_clk_run
);
   import port_pkg::*;
   // ==========================================================
   // Shadow of the written clock and output-enable fields
   logic            wr, clk_wr, key_ok, run_in_debug_ff, slp_ff;
   logic [1:0]      src_ff;
   logic [PINS-1:0] oen_ff;
   assign wr     = psel && penable && pready && pwrite;
   assign clk_wr = wr && paddr == CLKCTL_OFS;
   assign key_ok = pwdata[15:0] == UNLOCK_KEY;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {src_ff, run_in_debug_ff, slp_ff, oen_ff} <= '0;
      end else begin
         if (clk_wr) {slp_ff, run_in_debug_ff} <= {pwdata[SLPSTOP_BIT], pwdata[RUN_IN_DEBUG_BIT]};
         if (clk_wr && !protect_on) src_ff <= pwdata[CLKSRC_LSB +: 2];
         if (wr && paddr == IOEN_OFS) oen_ff <= pwdata[IOEN_OUT_LSB +: PINS];
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_prot_wr;
      wr && paddr == PROT_OFS;
   endsequence
   sequence s_halted;
      (debug_mode && !run_in_debug_ff) [*3];
   endsequence
   property p_reset_pins;
      $rose(rst_n) |-> &pin_oe_n && pin_pull_en == '0 && pin_periph == '0;
   endproperty
   property p_relock;
      s_prot_wr |=> protect_on == !$past(key_ok);
   endproperty
   property p_pull_off;
      (~pin_oe_n & pin_pull_en) == '0;
   endproperty
   property p_oe;
      $stable(oen_ff) [*2] |-> ((pin_oe_n ^ ~oen_ff) & ~pin_periph) == '0;
   endproperty
   property p_src_off;
      (!src_clk_en[src_ff]) [*3] |-> !filter_clk_run;
   endproperty
   property p_sleep;
      (sleep_mode && slp_ff) [*3] |-> !filter_clk_run;
   endproperty
   property p_halt;
      s_halted |-> !filter_clk_run;
   endproperty
   property p_dbg_run;
      (debug_mode && run_in_debug_ff && !sleep_mode && src_clk_en[src_ff]) [*3] |-> filter_clk_run;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins not idle after reset");
   a_relock: assert property (p_relock) else $error("protection state wrong");
   a_pull_off: assert property (p_pull_off) else $error("pull on while driving");
   a_oe: assert property (p_oe) else $error("output enable mismatch");
   a_src_off: assert property (p_src_off) else $error("clock runs, source off");
   a_sleep: assert property (p_sleep) else $error("clock runs in sleep");
   a_halt: assert property (p_halt) else $error("clock runs in debug");
   a_dbg_run: assert property (p_dbg_run) else $error("clock stopped in debug");
endmodule // port_props

bind port_controller port_props #(.PINS(PINS), .NUM_SRC(NUM_SRC)) u_props (.core_clk, .rst_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .sleep_mode, .debug_mode, .src_clk_en,
   .pin_oe_n, .pin_pull_en, .pin_periph, .protect_on, .filter_clk_run);

// [pin_model.sv]
// External pin model: design drive, bench drive, pull resistors, floating.
// Assumes the bench drives a pin only through ext_en and ext_val.
`timescale 1ns/1ps
module pin_model #(
   parameter int PINS = 8
) (
   input  wire logic            core_clk,
   input  wire logic [PINS-1:0] pin_out,
   input  wire logic [PINS-1:0] pin_oe_n,
   input  wire logic [PINS-1:0] pin_pull_en,
   input  wire logic [PINS-1:0] pin_pull_up,
   input  wire logic [PINS-1:0] ext_en,
   input  wire logic [PINS-1:0] ext_val,
   output logic      [PINS-1:0] pin_in
);
   logic [PINS-1:0] float_ff = '0;
   // An undriven, unpulled line wanders every cycle
   always @(posedge core_clk) float_ff <= ~float_ff;
   // Design drive wins, then the bench, then the pull
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pull_en[i]) pin_in[i] = pin_pull_up[i];
         else pin_in[i] = float_ff[i];
      end
   end
endmodule // pin_model

// [testbench.sv]
// Bench for the port controller: APB traffic, pins, filter clock gating.
// Assumes the pin model on the pins and the bound checker.
`timescale 1ns/1ps
module testbench;
   import port_pkg::*;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        sleep_mode, debug_mode, protect_on, filter_clk_run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, m;
   logic [3:0]  src_clk_en;
   logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pull_en, pin_pull_up, pin_periph, periph_in;
   logic [7:0]  ext_en, ext_val, rnd;
   logic [15:0] pin_func;
   logic [32:0] exp_q[$], e;
   logic [31:0] msk_q[$];
   logic [11:0] ra[7] = '{PROT_OFS, CLKCTL_OFS, IOEN_OFS, PULL_OFS, FILT_OFS, FUNC_OFS, MODE_OFS};
   logic [31:0] rm[7] = '{32'h1, 32'h3F3, 32'hFFFF, 32'hFFFF, 32'hFF, 32'hFFFF, 32'hFF};
   int          n_errors = 0;
   int          n_tests = 0;
   port_controller #(.PINS(8), .DBG_MASK(0), .NUM_SRC(4)) uut (.core_clk, .rst_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sleep_mode,
      .debug_mode, .src_clk_en, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en, .pin_pull_up,
      .pin_periph, .pin_func, .periph_in, .protect_on, .filter_clk_run);
   pin_model #(.PINS(8)) pins (.core_clk, .pin_out, .pin_oe_n, .pin_pull_en, .pin_pull_up,
      .ext_en, .ext_val, .pin_in);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic final_report;
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic reset;
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask
   // One APB transfer, held until pready, then released for a cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         n_errors++;
         final_report();
      end
      @(posedge core_clk);
   endtask
   // Note the expected word, then read it
   task automatic chk(input logic [11:0] a, input logic [32:0] ev, input logic [31:0] mv);
      exp_q.push_back(ev);
      msk_q.push_back(mv);
      apb(1'b0, a, 32'h0);
   endtask
   // Direct compare of a settled pin-side output
   task automatic cmp(input logic [31:0] got, input logic [31:0] ev);
      n_tests++;
      if (got !== ev) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, ev);
      end
   endtask
   // Compare each returned read with the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         n_tests++;
         if ((({pslverr, prdata} ^ e) & {1'b1, m}) !== 33'h0) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, {pslverr, prdata}, e);
         end
      end
   end
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, sleep_mode, debug_mode} = 6'h0;
      {paddr, pwdata, ext_en, ext_val} = '0;
      src_clk_en = 4'h5;
      rnd = 8'h54;
      reset();
      foreach (ra[i]) chk(ra[i], 33'h0, rm[i]);
      chk(12'h024, 33'h1_0000_0000, 32'h0);
      apb(1'b1, CLKCTL_OFS, 32'h53);
      chk(CLKCTL_OFS, 33'h0, 32'hF3);
      apb(1'b1, PROT_OFS, 32'h96);
      chk(PROT_OFS, 33'h1, 32'h1);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, CLKCTL_OFS, 32'h11 * s);
         chk(CLKCTL_OFS, {1'b0, 32'h11 * s}, 32'hF3);
         chk(STATUS_OFS, {32'h0, src_clk_en[s]}, 32'h1);
      end
      sleep_mode <= 1'b1;
      apb(1'b1, CLKCTL_OFS, 32'h200);
      chk(STATUS_OFS, 33'h0, 32'h1);
      apb(1'b1, CLKCTL_OFS, 32'h0);
      chk(STATUS_OFS, 33'h1, 32'h1);
      sleep_mode <= 1'b0;
      debug_mode <= 1'b1;
      ext_en <= 8'hFF;
      ext_val <= 8'h3;
      apb(1'b1, FILT_OFS, 32'h2);
      chk(STATUS_OFS, 33'h0, 32'h1);
      chk(FILT_OFS, 33'h2, 32'hFF);
      apb(1'b1, IOEN_OFS, 32'hFF);
      repeat (4) @(posedge core_clk);
      chk(DATA_OFS, 33'h100, 32'h300);
      apb(1'b1, CLKCTL_OFS, 32'h100);
      chk(STATUS_OFS, 33'h1, 32'h1);
      apb(1'b1, CLKCTL_OFS, 32'h20);
      debug_mode <= 1'b0;
      ext_val <= 8'h0;
      apb(1'b1, FILT_OFS, 32'h1);
      chk(STATUS_OFS, 33'h1, 32'h1);
      repeat (30) @(posedge core_clk);
      ext_val <= 8'h1;
      repeat (2) @(posedge core_clk);
      ext_val <= 8'h0;
      // Read while an unfiltered pulse would still show
      chk(DATA_OFS, 33'h0, 32'h100);
      ext_val <= 8'h3;
      repeat (30) @(posedge core_clk);
      chk(DATA_OFS, 33'h300, 32'h300);
      apb(1'b1, PROT_OFS, 32'h97);
      chk(PROT_OFS, 33'h0, 32'h1);
      ext_en <= 8'h0;
      apb(1'b1, FILT_OFS, 32'h0);
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         apb(1'b1, PULL_OFS, {16'h0, rnd, 8'hFF});
         repeat (4) @(posedge core_clk);
         chk(DATA_OFS, {17'h0, rnd, 8'h0}, 32'hFF00);
      end
      apb(1'b1, DATA_OFS, {24'h0, ~rnd});
      apb(1'b1, IOEN_OFS, 32'hFFFF);
      repeat (4) @(posedge core_clk);
      chk(DATA_OFS, {17'h0, ~rnd, ~rnd}, 32'hFFFF);
      apb(1'b1, IOEN_OFS, 32'hFF);
      repeat (4) @(posedge core_clk);
      chk(DATA_OFS, {17'h0, rnd, ~rnd}, 32'hFFFF);
      apb(1'b1, FUNC_OFS, 32'hE4E4);
      apb(1'b1, MODE_OFS, 32'hFF);
      chk(FUNC_OFS, 33'hE4E4, 32'hFFFF);
      chk(MODE_OFS, 33'hFF, 32'hFF);
      cmp({16'h0, pin_func}, 32'hE4E4);
      cmp({24'h0, periph_in}, {24'h0, rnd});
      apb(1'b1, IOEN_OFS, 32'h0);
      repeat (4) @(posedge core_clk);
      cmp({24'h0, periph_in}, 32'h0);
      chk(DATA_OFS, 33'h0, 32'hFF00);
      reset();
      chk(IOEN_OFS, 33'h0, 32'hFFFF);
      final_report();
   end
endmodule // testbench
